// ===== tb/front_side_bus_arbitration_strobes_bench.sv
// Purpose: Bench joining processor end and chipset end.
// Assumes: Strap select 1; lock raised in one case only.
// Notes:   Results read at negedge, except end_txn fields and the lock-case priority check (after posedge).
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin \
  fail_count++; $display("BAD %0t %h %h", $time, a, b); end end
module front_side_bus_arbitration_strobes_bench;
  import fsb_pkg::*;
  logic     mclk_i, rst_n_i, req_valid, busy, full, pri, probe, lock;
  logic     acc, got, st, ads_seen, txn_start, txn_valid, dev_req;
  logic     probe_ready, req_accept, agent_id, debug_mode;
  logic [1:0] bp_hit;
  addr_t    req_addr, req_attr, txn_addr, txn_attr;
  reqtype_t req_type, txn_type, txn_type2;
  int       fail_count = 0;
  int       compares = 0;
  addr_t    pa[3] = '{33'h0, 33'h1ffffffff, 33'h0aaaa5555};
  reqtype_t pt[3] = '{5'h00, 5'h1f, 5'h15};
  fsb_if bus_if ();
  fsb_device fsb_device_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus(bus_if),
    .req_valid_i(req_valid), .req_addr_i(req_addr), .req_type_i(req_type),
    .req_attr_i(req_attr), .req_lock_i(lock), .busy_i(busy),
    .bp_hit_i(bp_hit), .req_accept_o(req_accept), .agent_id_o(agent_id),
    .debug_mode_o(debug_mode));
  fsb_chipset fsb_chipset_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .bus(bus_if), .pri_req_i(pri), .full_i(full), .probe_req_i(probe),
    .txn_start_o(txn_start), .txn_valid_o(txn_valid),
    .txn_addr_o(txn_addr), .txn_type_o(txn_type), .txn_attr_o(txn_attr),
    .txn_type2_o(txn_type2), .dev_req_o(dev_req),
    .probe_ready_o(probe_ready));
  fsb_monitor fsb_monitor_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .req_lock_i(lock),
    .bus_clock(bus_if.bus_clock),
    .address_lines_n(bus_if.address_lines_n),
    .address_strobe_pair_n(bus_if.address_strobe_pair_n),
    .address_valid_strobe_n(bus_if.address_valid_strobe_n),
    .block_next_request_n(bus_if.block_next_request_n),
    .priority_agent_request_n(bus_if.priority_agent_request_n),
    .clock_frequency_select(bus_if.clock_frequency_select),
    .breakpoint_monitor_lines_n(bus_if.breakpoint_monitor_lines_n));
  // ---------------------------------------
  // Tasks
  // ---------------------------------------
  task automatic print_verdict();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic start_txn(input addr_t a, input reqtype_t t, input addr_t r);
    @(posedge mclk_i);
    req_addr <= a;
    req_type <= t;
    req_attr <= r;
    req_valid <= 1'b1;
  endtask
  // Request held until accept; chipset side compared after
  task automatic end_txn(input addr_t a, input reqtype_t t, input addr_t r);
    acc = 0;
    got = 0;
    st = 0;
    for (int i = 0; i < 400 && !(acc && got); i++) begin
      @(negedge mclk_i);
      if (txn_valid === 1'b1) got = 1;
      if (req_accept === 1'b1) acc = 1;
      if (txn_start === 1'b1) st = 1;
    end
    @(posedge mclk_i);
    req_valid <= 1'b0;
    `CHK({acc, got, st}, 3'h7)
    `CHK(txn_addr, a)
    `CHK(txn_type, t)
    `CHK(txn_attr, r)
    `CHK(txn_type2, t)
  endtask
  // Block first, then request, so the issue cannot race the stall
  task automatic block_case(input int sel);
    @(posedge mclk_i);
    full <= (sel == 0);
    pri <= (sel == 1);
    repeat (40) @(posedge mclk_i);
    start_txn(pa[2], pt[2], ~pa[2]);
    ads_seen = 0;
    repeat (120) begin
      @(negedge mclk_i);
      if (bus_if.address_valid_strobe_n === 1'b0) ads_seen = 1;
    end
    `CHK(ads_seen, 1'b0)
    `CHK({bus_if.block_next_request_n, bus_if.priority_agent_request_n},
         (sel == 1) ? 2'h2 : 2'h1)
    `CHK(bus_if.system_bus_request_zero_n, 1'b0)
    `CHK(dev_req, 1'b1)
    @(posedge mclk_i);
    full <= 1'b0;
    pri <= 1'b0;
    end_txn(pa[2], pt[2], ~pa[2]);
  endtask
  // ---------------------------------------
  // Sequence
  // ---------------------------------------
  initial begin
    mclk_i = 0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    print_verdict();
  end
  initial begin
    {rst_n_i, req_valid, busy, full, pri, probe, lock, bp_hit} = '0;
    {req_addr, req_type, req_attr} = '0;
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (40) @(negedge mclk_i);
    `CHK(agent_id, 1'b0)
    `CHK(bus_if.clock_frequency_select, 3'h1)
    for (int i = 0; i < 3; i++) begin
      start_txn(pa[i], pt[i], ~pa[i]);
      end_txn(pa[i], pt[i], ~pa[i]);
    end
    block_case(0);
    block_case(1);
    // Locked request must pass a standing priority request
    @(posedge mclk_i);
    pri <= 1'b1;
    lock <= 1'b1;
    repeat (40) @(posedge mclk_i);
    start_txn(pa[1], pt[2], ~pa[2]);
    end_txn(pa[1], pt[2], ~pa[2]);
    `CHK(bus_if.priority_agent_request_n, 1'b0)
    @(posedge mclk_i);
    pri <= 1'b0;
    lock <= 1'b0;
    busy <= 1'b1;
    bp_hit <= 2'h2;
    repeat (40) @(negedge mclk_i);
    `CHK(bus_if.block_next_request_n, 1'b0)
    `CHK(bus_if.breakpoint_monitor_lines_n[3:0], 4'h5)
    @(posedge mclk_i);
    busy <= 1'b0;
    probe <= 1'b1;
    repeat (40) @(negedge mclk_i);
    `CHK(debug_mode, 1'b1)
    `CHK(bus_if.breakpoint_monitor_lines_n[4], 1'b0)
    `CHK(probe_ready, 1'b1)
    @(posedge mclk_i);
    probe <= 1'b0;
    repeat (20) @(negedge mclk_i);
    `CHK({debug_mode, probe_ready}, 2'h0)
    print_verdict();
  end
endmodule // front_side_bus_arbitration_strobes_bench

// ===== tb/fsb_monitor.sv
// Purpose: Bus-side checks between the two ends.
// Assumes: Strap select 1, bus clock half period 8 mclk.
// Notes:   Locked requests are exempt from the priority check.
`timescale 1ns/1ps
module fsb_monitor (
  input wire logic           mclk_i,
  input wire logic           rst_n_i,
  input wire logic           req_lock_i,
  input wire logic           bus_clock,
  input wire fsb_pkg::addr_t address_lines_n,
  input wire logic [1:0]     address_strobe_pair_n,
  input wire logic           address_valid_strobe_n,
  input wire logic           block_next_request_n,
  input wire logic           priority_agent_request_n,
  input wire logic [2:0]     clock_frequency_select,
  input wire logic [5:0]     breakpoint_monitor_lines_n
);
  import fsb_pkg::*;
  // ---------------------------------------
  // Checks
  // ---------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_issue; $fell(address_valid_strobe_n); endsequence
  property p_ads_hold; s_issue |-> !address_valid_strobe_n [*8]; endproperty
  a_ads_hold: assert property (p_ads_hold)
    else $error("address valid released early");
  property p_stb_fall; s_issue |-> ##5 address_strobe_pair_n == 2'h0;
  endproperty
  a_stb_fall: assert property (p_stb_fall)
    else $error("strobes not low at sub-phase one");
  property p_stb_rise; s_issue |-> ##13 address_strobe_pair_n == 2'h3;
  endproperty
  a_stb_rise: assert property (p_stb_rise)
    else $error("strobes not high at sub-phase two");
  property p_addr_hold; s_issue |=> $stable(address_lines_n) [*7];
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved inside sub-phase one");
  // Six cycles covers the sync delay of the stall line
  property p_stall;
    !block_next_request_n [*6] |=> !$fell(address_valid_strobe_n);
  endproperty
  a_stall: assert property (p_stall)
    else $error("issue during stall");
  property p_prio;
    (!priority_agent_request_n && !req_lock_i) [*6]
      |=> !$fell(address_valid_strobe_n);
  endproperty
  a_prio: assert property (p_prio)
    else $error("issue under priority request");
  property p_freq; $rose(bus_clock) |-> clock_frequency_select == 3'h1;
  endproperty
  a_freq: assert property (p_freq)
    else $error("frequency select wrong");
  property p_bclk; $rose(bus_clock) |-> bus_clock [*8] ##[1:3] !bus_clock;
  endproperty
  a_bclk: assert property (p_bclk)
    else $error("bus clock half period wrong");
  property p_probe;
    $fell(breakpoint_monitor_lines_n[5])
      |-> ##[1:20] !breakpoint_monitor_lines_n[4];
  endproperty
  a_probe: assert property (p_probe)
    else $error("probe ready missing");
endmodule // fsb_monitor

// ===== verilog/fsb_chipset.sv
// Purpose: Chipset end: bus clock, priority, stall, address receive.
// Assumes: Single requesting processor on the bus.
// Notes:   Also acts as the debug tool on monitor line 5.
`timescale 1ns/1ps
`include "fsb_defs.svh"
module fsb_chipset (
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  fsb_if.chipset                 bus,
  input  wire logic              pri_req_i,
  input  wire logic              full_i,
  input  wire logic              probe_req_i,
  output logic                   txn_start_o,
  output logic                   txn_valid_o,
  output fsb_pkg::addr_t         txn_addr_o,
  output fsb_pkg::reqtype_t      txn_type_o,
  output fsb_pkg::addr_t         txn_attr_o,
  output fsb_pkg::reqtype_t      txn_type2_o,
  output logic                   dev_req_o,
  output logic                   probe_ready_o
);
  import fsb_pkg::*;

  logic [1:0] ads_sync;
  logic       ads_prev;
  logic [1:0] breq_sync;
  logic [1:0] probe_ready_sync;
  logic [2:0] sel_meta;
  logic [2:0] sel_sync;
  logic [3:0] half_cnt;
  logic       bclk_rise;
  logic [4:0] cfg_cnt;
  group_t     g0_first;
  group_t     g0_second;
  group_t     g1_first;
  group_t     g1_second;
  logic       g0_valid;
  logic       g1_valid;

  function automatic logic [3:0] half_of(input logic [2:0] sel);
    case (sel)
      3'h0:    half_of = 4'(`BCLK_HALF_SEL0);
      3'h2:    half_of = 4'(`BCLK_HALF_SEL2);
      default: half_of = 4'(`BCLK_HALF_CYC);
    endcase
  endfunction

  // ------------------------------------------------------------
  // Receive synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ads_sync  <= 2'h3;
      ads_prev  <= 1'b1;
      breq_sync <= 2'h3;
      probe_ready_sync <= 2'h3;
      sel_meta  <= 3'h0;
      sel_sync  <= 3'h0;
    end else begin
      ads_sync  <= {ads_sync[0], bus.address_valid_strobe_n};
      ads_prev  <= ads_sync[1];
      breq_sync <= {breq_sync[0], bus.system_bus_request_zero_n};
      probe_ready_sync <= {probe_ready_sync[0], bus.breakpoint_monitor_lines_n[4]};
      sel_meta  <= bus.clock_frequency_select;
      sel_sync  <= sel_meta;
    end
  end

  // ------------------------------------------------------------
  // Bus clock divider at the rate the processor selects
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      half_cnt      <= 4'h0;
      bus.bus_clock <= 1'b0;
    end else if (half_cnt >= half_of(sel_sync) - 4'h1) begin
      half_cnt      <= 4'h0;
      bus.bus_clock <= !bus.bus_clock; // [R13] [R3]
    end else begin
      half_cnt <= half_cnt + 4'h1;
    end
  end

  assign bclk_rise = (half_cnt >= half_of(sel_sync) - 4'h1)
                  && !bus.bus_clock;

  // ------------------------------------------------------------
  // Priority request, stall and reset-time bus request
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus.priority_agent_request_n <= 1'b1;
      bus.cs_bnr_o  <= 1'b0;
      bus.cs_bnr_oe <= 1'b0;
    end else if (bclk_rise) begin
      // User keeps pri_req_i until all its own requests complete
      bus.priority_agent_request_n <= !pri_req_i; // [R10] [R16]
      bus.cs_bnr_oe <= full_i; // [R4]
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_cnt        <= 5'h00;
      bus.cs_breq_o  <= 1'b0;
      bus.cs_breq_oe <= 1'b0;
    end else if (cfg_cnt != `CFG_HOLD_CNT) begin
      cfg_cnt        <= cfg_cnt + 5'h01;
      bus.cs_breq_oe <= 1'b1; // [R12]
    end else begin
      bus.cs_breq_oe <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus.cs_probe_o  <= 1'b1;
      bus.cs_probe_oe <= 1'b0;
      probe_ready_o   <= 1'b0;
      dev_req_o       <= 1'b0;
    end else begin
      bus.cs_probe_oe <= 1'b1;
      bus.cs_probe_o  <= !probe_req_i; // [R8]
      probe_ready_o   <= !probe_ready_sync[1]; // [R7]
      dev_req_o       <= !breq_sync[1] && cfg_cnt == `CFG_HOLD_CNT;
    end
  end

  // ------------------------------------------------------------
  // Address receive, one capture per strobe group
  // ------------------------------------------------------------
  strobe_capture #(.W(`G_W)) u_grp0 (
    .mclk_i       (mclk_i),
    .rst_n_i      (rst_n_i),
    .strobe_n_i   (bus.address_strobe_pair_n[0]),
    .data_n_i     ({bus.request_type_n, bus.address_lines_n[16:3]}), // [R2]
    .first_o      (g0_first),
    .second_o     (g0_second),
    .pair_valid_o (g0_valid)
  );

  strobe_capture #(.W(`G_W)) u_grp1 (
    .mclk_i       (mclk_i),
    .rst_n_i      (rst_n_i),
    .strobe_n_i   (bus.address_strobe_pair_n[1]),
    .data_n_i     (bus.address_lines_n[35:17]), // [R2]
    .first_o      (g1_first),
    .second_o     (g1_second),
    .pair_valid_o (g1_valid)
  );

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      txn_start_o <= 1'b0;
      txn_valid_o <= 1'b0;
      txn_addr_o  <= '0;
      txn_type_o  <= '0;
      txn_attr_o  <= '0;
      txn_type2_o <= '0;
    end else begin
      txn_start_o <= ads_prev && !ads_sync[1]; // [R15]
      txn_valid_o <= g0_valid && g1_valid;
      if (g0_valid && g1_valid) begin
        txn_addr_o  <= {g1_first, g0_first[`G0_ADDR_W-1:0]}; // [R14]
        txn_type_o  <= g0_first[`G_W-1:`G0_ADDR_W];
        txn_attr_o  <= {g1_second, g0_second[`G0_ADDR_W-1:0]}; // [R14]
        txn_type2_o <= g0_second[`G_W-1:`G0_ADDR_W];
      end
    end
  end
endmodule // fsb_chipset

// ===== verilog/fsb_defs.svh
// Purpose: Constants shared by both bus ends.
// Assumes: mclk_i at 200 MHz; bus clock made by the chipset end.
// Notes:   All bus control levels are active low.
// Function
// R1: capture address and type on both strobe edges
// R2: strobe 0 carries type, a16..3; strobe 1 a35..17
// R3: all agents time from the bus clock
// R4: agent unable to accept asserts block request
// R5: owner issues nothing while stall is signalled
// R6: device drives breakpoint and counter status lines
// R7: monitor line 4 is probe ready output
// R8: monitor line 5 is probe request input
// R9: priority request stops issue except locked
// R10: priority agent holds request until its work done
// R11: device drives bus request to system line zero
// R12: reset sample of bus request gives agent id
// R13: device drives frequency select; all agents follow
// R14: sub-phase one address, sub-phase two type info
// R15: address valid strobe marks lines, starts decode
// R16: every control signal is active low
`ifndef FSB_DEFS_SVH
`define FSB_DEFS_SVH
`define MCLK_PERIOD_NS 5
`define BCLK_PERIOD_NS 80
`define BCLK_HALF_CYC (`BCLK_PERIOD_NS / (2 * `MCLK_PERIOD_NS))
`define BCLK_HALF_SEL0 10
`define BCLK_HALF_SEL2 6
`define FREQ_SEL_STRAP 3'h1
`define STB_FALL_CNT 5'h04
`define SUB2_CNT 5'h08
`define STB_RISE_CNT 5'h0c
`define ISSUE_END_CNT 5'h10
`define CFG_SAMPLE_CNT 5'h08
`define CFG_HOLD_CNT 5'h10
`define G0_ADDR_W 14
`define G_W 19
`define REQ_W 5
`endif

// ===== verilog/fsb_device.sv
// Purpose: Processor end: request, arbitration, address issue, monitors.
// Assumes: Bus clock runs at the selected rate, 16 mclk per period.
// Notes:   Issue timing is counted in mclk from the bus clock rise.
`timescale 1ns/1ps
`include "fsb_defs.svh"
module fsb_device (
  input  wire logic           mclk_i,
  input  wire logic           rst_n_i,
  fsb_if.device               bus,
  input  wire logic           req_valid_i,
  input  wire fsb_pkg::addr_t req_addr_i,
  input  wire fsb_pkg::reqtype_t req_type_i,
  input  wire fsb_pkg::addr_t req_attr_i,
  input  wire logic           req_lock_i,
  input  wire logic           busy_i,
  input  wire logic [1:0]     bp_hit_i,
  output logic                req_accept_o,
  output logic                agent_id_o,
  output logic                debug_mode_o
);
  import fsb_pkg::*;

  dev_state_e state;
  dev_state_e next_state;
  logic [1:0] clk_sync;
  logic       clk_prev;
  logic [1:0] bnr_sync;
  logic [1:0] priority_agent_request_sync;
  logic [1:0] breq_sync;
  logic [1:0] probe_sync;
  logic       bclk_rise;
  logic       may_issue;
  logic [4:0] ph_cnt;
  logic [4:0] cfg_cnt;
  logic       cfg_done;
  logic [7:0] perf_cnt;
  logic       stall_seen;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_sync   <= 2'h0;
      clk_prev   <= 1'b0;
      bnr_sync   <= 2'h3;
      priority_agent_request_sync  <= 2'h3;
      breq_sync  <= 2'h3;
      probe_sync <= 2'h3;
    end else begin
      clk_sync   <= {clk_sync[0], bus.bus_clock};
      clk_prev   <= clk_sync[1];
      bnr_sync   <= {bnr_sync[0], bus.block_next_request_n};
      priority_agent_request_sync  <= {priority_agent_request_sync[0], bus.priority_agent_request_n};
      breq_sync  <= {breq_sync[0], bus.system_bus_request_zero_n};
      probe_sync <= {probe_sync[0], bus.breakpoint_monitor_lines_n[5]};
    end
  end

  assign bclk_rise = clk_sync[1] && !clk_prev; // [R3]
  // Stall and priority hold off issue; locked sequences may pass priority, not stall
  assign may_issue = bnr_sync[1] // [R5]
                  && (priority_agent_request_sync[1] || req_lock_i); // [R9] [R16]

  // ------------------------------------------------------------
  // Power-on configuration
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_cnt    <= 5'h00;
      cfg_done   <= 1'b0;
      agent_id_o <= 1'b0;
    end else if (!cfg_done) begin
      cfg_cnt <= cfg_cnt + 5'h01;
      if (cfg_cnt == `CFG_SAMPLE_CNT) begin
        cfg_done   <= 1'b1;
        // Line held low by the system at reset means agent zero
        agent_id_o <= breq_sync[1]; // [R12]
      end
    end
  end

  // ------------------------------------------------------------
  // Request state machine
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (!probe_sync[1]) begin
          next_state = ST_DEBUG; // [R8]
        end else if (req_valid_i && cfg_done) begin
          next_state = ST_ARB;
        end
      end
      ST_ARB: begin
        if (bclk_rise && may_issue) begin
          next_state = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        if (ph_cnt == `ISSUE_END_CNT) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      ST_DEBUG: begin
        if (probe_sync[1]) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_cnt <= 5'h00;
    end else if (state == ST_ISSUE) begin
      ph_cnt <= ph_cnt + 5'h01;
    end else begin
      ph_cnt <= 5'h00;
    end
  end

  // ------------------------------------------------------------
  // Bus request, kept off the line until configuration ends
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus.bus_request_out_n  <= 1'b1;
      bus.bus_request_out_oe <= 1'b0;
    end else begin
      bus.bus_request_out_oe <= cfg_done;
      bus.bus_request_out_n  <= !(next_state == ST_ARB
                                  || next_state == ST_ISSUE); // [R11]
    end
  end

  // ------------------------------------------------------------
  // Address phase: two sub-phases, both strobes toggle together
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus.dev_addr_n    <= '1;
      bus.dev_reqtype_n <= '1;
      bus.dev_addr_oe   <= 1'b0;
      bus.dev_strobe_n  <= 2'h3;
      bus.dev_strobe_oe <= 1'b0;
      bus.dev_ads_n     <= 1'b1;
      bus.dev_ads_oe    <= 1'b0;
      req_accept_o      <= 1'b0;
    end else begin
      req_accept_o <= 1'b0;
      if (state == ST_ARB && next_state == ST_ISSUE) begin
        bus.dev_addr_n    <= ~req_addr_i; // [R14] [R16]
        bus.dev_reqtype_n <= ~req_type_i;
        bus.dev_addr_oe   <= 1'b1;
        bus.dev_strobe_oe <= 1'b1;
        bus.dev_ads_n     <= 1'b0; // [R15]
        bus.dev_ads_oe    <= 1'b1;
      end else if (state == ST_ISSUE) begin
        case (ph_cnt)
          `STB_FALL_CNT: bus.dev_strobe_n <= 2'h0; // [R1] [R2]
          `SUB2_CNT:     bus.dev_addr_n   <= ~req_attr_i; // [R14]
          `STB_RISE_CNT: bus.dev_strobe_n <= 2'h3; // [R1] [R2]
          `ISSUE_END_CNT: begin
            bus.dev_ads_n <= 1'b1;
            req_accept_o  <= 1'b1;
          end
          default: begin
          end
        endcase
      end else begin
        bus.dev_addr_n    <= '1;
        bus.dev_reqtype_n <= '1;
        bus.dev_addr_oe   <= 1'b0;
        bus.dev_strobe_oe <= 1'b0;
        bus.dev_ads_oe    <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Stall output, updated on bus clock rise
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus.dev_bnr_o  <= 1'b0;
      bus.dev_bnr_oe <= 1'b0;
    end else if (bclk_rise) begin
      bus.dev_bnr_oe <= busy_i; // [R4] [R3]
    end
  end

  // ------------------------------------------------------------
  // Monitor lines and performance counter
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      perf_cnt   <= 8'h00;
      stall_seen <= 1'b0;
    end else begin
      if (req_accept_o) begin
        perf_cnt <= perf_cnt + 8'h01;
      end
      stall_seen <= !bnr_sync[1];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus.dev_bpm_n  <= 5'h1f;
      bus.dev_bpm_oe <= 1'b0;
      debug_mode_o   <= 1'b0;
    end else begin
      bus.dev_bpm_oe <= 1'b1;
      bus.dev_bpm_n  <= {!(next_state == ST_DEBUG), // [R7]
                         !stall_seen, !perf_cnt[7], // [R6]
                         ~bp_hit_i}; // [R6]
      debug_mode_o   <= (next_state == ST_DEBUG);
    end
  end

  // Frequency strap is fixed; a change needs a reset of all agents
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus.clock_frequency_select <= 3'h0;
    end else begin
      bus.clock_frequency_select <= `FREQ_SEL_STRAP; // [R13]
    end
  end
endmodule // fsb_device

// ===== verilog/fsb_if.sv
// Purpose: Bus wires between processor end and chipset end.
// Assumes: Undriven lines float high (deasserted).
// Notes:   Open-drain lines resolve as wired-AND of drivers.
`timescale 1ns/1ps
interface fsb_if;
  import fsb_pkg::*;
  logic       bus_clock;
  addr_t      dev_addr_n;
  reqtype_t   dev_reqtype_n;
  logic       dev_addr_oe;
  logic [1:0] dev_strobe_n;
  logic       dev_strobe_oe;
  logic       dev_ads_n;
  logic       dev_ads_oe;
  logic       dev_bnr_o;
  logic       dev_bnr_oe;
  logic       cs_bnr_o;
  logic       cs_bnr_oe;
  logic       priority_agent_request_n;
  logic       bus_request_out_n;
  logic       bus_request_out_oe;
  logic       cs_breq_o;
  logic       cs_breq_oe;
  logic [4:0] dev_bpm_n;
  logic       dev_bpm_oe;
  logic       cs_probe_o;
  logic       cs_probe_oe;
  logic [2:0] clock_frequency_select;
  addr_t      address_lines_n;
  reqtype_t   request_type_n;
  logic [1:0] address_strobe_pair_n;
  logic       address_valid_strobe_n;
  logic       block_next_request_n;
  logic       system_bus_request_zero_n;
  logic [5:0] breakpoint_monitor_lines_n;

  assign address_lines_n  = dev_addr_oe ? dev_addr_n : '1;
  assign request_type_n   = dev_addr_oe ? dev_reqtype_n : '1;
  assign address_strobe_pair_n = dev_strobe_oe ? dev_strobe_n : 2'h3;
  assign address_valid_strobe_n = dev_ads_oe ? dev_ads_n : 1'b1;
  assign block_next_request_n = (dev_bnr_oe ? dev_bnr_o : 1'b1)
                              & (cs_bnr_oe ? cs_bnr_o : 1'b1);
  assign system_bus_request_zero_n =
      (bus_request_out_oe ? bus_request_out_n : 1'b1)
    & (cs_breq_oe ? cs_breq_o : 1'b1);
  assign breakpoint_monitor_lines_n[4:0] = dev_bpm_oe ? dev_bpm_n : 5'h1f;
  assign breakpoint_monitor_lines_n[5] = cs_probe_oe ? cs_probe_o : 1'b1;

  modport device (
    input  bus_clock, priority_agent_request_n, address_lines_n,
           block_next_request_n, system_bus_request_zero_n,
           breakpoint_monitor_lines_n,
    output dev_addr_n, dev_reqtype_n, dev_addr_oe, dev_strobe_n,
           dev_strobe_oe, dev_ads_n, dev_ads_oe, dev_bnr_o, dev_bnr_oe,
           bus_request_out_n, bus_request_out_oe, dev_bpm_n, dev_bpm_oe,
           clock_frequency_select
  );
  modport chipset (
    input  address_lines_n, request_type_n, address_strobe_pair_n,
           address_valid_strobe_n, block_next_request_n,
           system_bus_request_zero_n, breakpoint_monitor_lines_n,
           clock_frequency_select,
    output bus_clock, priority_agent_request_n, cs_bnr_o, cs_bnr_oe,
           cs_breq_o, cs_breq_oe, cs_probe_o, cs_probe_oe
  );
endinterface

// ===== verilog/fsb_pkg.sv
// Purpose: Types shared by both bus ends.
// Assumes: Constants come from fsb_defs.svh.
// Notes:   State codes are one-hot.
package fsb_pkg;
  typedef logic [35:3] addr_t;
  typedef logic [4:0]  reqtype_t;
  typedef logic [18:0] group_t;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_ARB   = 5'h02,
    ST_ISSUE = 5'h04,
    ST_DONE  = 5'h08,
    ST_DEBUG = 5'h10
  } dev_state_e;
endpackage

// ===== verilog/strobe_capture.sv
// Purpose: Dual-edge capture of one strobe group.
// Assumes: Sender holds data for more than three mclk cycles per edge.
// Notes:   Strobe and data share the same sync depth, so they stay aligned.
`timescale 1ns/1ps
module strobe_capture #(
  parameter int W = 19
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic         strobe_n_i,
  input  wire logic [W-1:0] data_n_i,
  output logic      [W-1:0] first_o,
  output logic      [W-1:0] second_o,
  output logic              pair_valid_o
);
  logic [1:0]   stb_sync;
  logic         stb_prev;
  logic [W-1:0] dat_meta;
  logic [W-1:0] dat_sync;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stb_sync <= 2'h3;
      stb_prev <= 1'b1;
      dat_meta <= '1;
      dat_sync <= '1;
    end else begin
      stb_sync <= {stb_sync[0], strobe_n_i};
      stb_prev <= stb_sync[1];
      dat_meta <= data_n_i;
      dat_sync <= dat_meta;
    end
  end

  // ------------------------------------------------------------
  // Falling edge takes sub-phase one, rising edge sub-phase two
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_o      <= '0;
      second_o     <= '0;
      pair_valid_o <= 1'b0;
    end else begin
      pair_valid_o <= 1'b0;
      if (stb_prev && !stb_sync[1]) begin
        first_o <= ~dat_sync; // [R1] [R16]
      end
      if (!stb_prev && stb_sync[1]) begin
        second_o     <= ~dat_sync; // [R1]
        pair_valid_o <= 1'b1;
      end
    end
  end
endmodule // strobe_capture
